// [cmr_ctrl.sv]
`timescale 1ns/1ps
`default_nettype none
module cmr_ctrl (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // Special-function-register bus
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  output logic [7:0] sfr_rdata,
  // Crossbar route register 0, same clock
  input wire logic [7:0] crossbar_route_reg0,
  // Analog comparator side
  input wire logic raw_compare_in,
  output logic [1:0] response_mode,
  output logic [3:0] pos_input_sel,
  output logic [3:0] neg_input_sel,
  // Port pins and interrupt
  output logic raw_compare_out,
  output logic synced_compare_out,
  output logic cmp_irq
);

  cmr_pkg::cmr_state_t st_r;
  cmr_pkg::cmr_state_t st_nxt;
  logic rise_ev;
  logic fall_ev;

  // Edges taken on the second synchroniser stage only
  assign rise_ev = st_r.sync2 & ~st_r.sync_prev;
  assign fall_ev = ~st_r.sync2 & st_r.sync_prev;

  // Next-state logic for the whole block
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = raw_compare_in;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sync_prev = st_r.sync2;
    if (sfr_wr && sfr_addr == cmr_pkg::MODE_ADDR) begin
      st_nxt.mode = sfr_wdata & cmr_pkg::MODE_WMASK;
    end
    if (sfr_wr && sfr_addr == cmr_pkg::MUX_ADDR) begin
      st_nxt.mux = sfr_wdata;
    end
    // Writing 0 clears a flag; a same-cycle edge still sets it
    if (sfr_wr && sfr_addr == cmr_pkg::FLAG_ADDR) begin
      st_nxt.rise_flag = st_r.rise_flag & sfr_wdata[cmr_pkg::RISE_FLAG_BIT];
      st_nxt.fall_flag = st_r.fall_flag & sfr_wdata[cmr_pkg::FALL_FLAG_BIT];
    end
    if (rise_ev) begin
      st_nxt.rise_flag = 1'b1;
    end
    if (fall_ev) begin
      st_nxt.fall_flag = 1'b1;
    end
    st_nxt.raw_en = crossbar_route_reg0[cmr_pkg::XBAR_RAW_BIT];
    st_nxt.sync_pin = st_r.sync2 & crossbar_route_reg0[cmr_pkg::XBAR_SYNC_BIT];
    st_nxt.irq = (st_r.rise_flag & st_r.mode[cmr_pkg::RISE_EN_BIT])
        | (st_r.fall_flag & st_r.mode[cmr_pkg::FALL_EN_BIT]);
    // Read data, zero for unmapped addresses
    st_nxt.rdata = 8'h00;
    if (sfr_rd) begin
      case (sfr_addr)
        cmr_pkg::MODE_ADDR: st_nxt.rdata = st_r.mode;
        cmr_pkg::MUX_ADDR: st_nxt.rdata = st_r.mux;
        cmr_pkg::FLAG_ADDR: begin
          st_nxt.rdata[cmr_pkg::OUT_BIT] = st_r.sync2;
          st_nxt.rdata[cmr_pkg::RISE_FLAG_BIT] = st_r.rise_flag;
          st_nxt.rdata[cmr_pkg::FALL_FLAG_BIT] = st_r.fall_flag;
        end
        default: st_nxt.rdata = 8'h00;
      endcase
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
      st_r.mode <= cmr_pkg::MODE_RST;
      st_r.mux <= cmr_pkg::MUX_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs; the raw pin must stay asynchronous, so only its enable is registered
  assign sfr_rdata = st_r.rdata;
  assign response_mode = st_r.mode[cmr_pkg::RMODE_LSB +: cmr_pkg::RMODE_W];
  assign pos_input_sel = st_r.mux[cmr_pkg::POS_LSB +: cmr_pkg::SEL_W];
  assign neg_input_sel = st_r.mux[cmr_pkg::NEG_LSB +: cmr_pkg::SEL_W];
  assign raw_compare_out = raw_compare_in & st_r.raw_en;
  assign synced_compare_out = st_r.sync_pin;
  assign cmp_irq = st_r.irq;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  property p_top_zero;
    sfr_wr && sfr_addr == cmr_pkg::MODE_ADDR |=> (st_r.mode & ~cmr_pkg::MODE_WMASK) == 8'h00;
  endproperty
  a_top_zero: assert property (p_top_zero) else $error("mode top bits not zero");

  property p_rise_gate;
    st_r.rise_flag && !st_r.mode[cmr_pkg::RISE_EN_BIT] && !st_r.fall_flag |=> !cmp_irq;
  endproperty
  a_rise_gate: assert property (p_rise_gate) else $error("rise irq not blocked");

  property p_mode_out;
    sfr_wr && sfr_addr == cmr_pkg::MODE_ADDR
        |=> response_mode == $past(sfr_wdata[cmr_pkg::RMODE_LSB +: cmr_pkg::RMODE_W]);
  endproperty
  a_mode_out: assert property (p_mode_out) else $error("response mode wrong");

  property p_mux_out;
    sfr_wr && sfr_addr == cmr_pkg::MUX_ADDR
        |=> {neg_input_sel, pos_input_sel} == $past(sfr_wdata);
  endproperty
  a_mux_out: assert property (p_mux_out) else $error("input select wrong");

  property p_raw_gate;
    !st_r.raw_en |-> !raw_compare_out;
  endproperty
  a_raw_gate: assert property (p_raw_gate) else $error("raw pin not gated");

  property p_sync_pin;
    ##1 synced_compare_out == ($past(st_r.sync2)
        && $past(crossbar_route_reg0[cmr_pkg::XBAR_SYNC_BIT]));
  endproperty
  a_sync_pin: assert property (p_sync_pin) else $error("synced pin wrong");

  property p_fall_irq;
    st_r.fall_flag && st_r.mode[cmr_pkg::FALL_EN_BIT] |=> cmp_irq;
  endproperty
  a_fall_irq: assert property (p_fall_irq) else $error("fall irq missing");

  sequence s_rise_seen;
    st_r.sync2 && !st_r.sync_prev;
  endsequence
  property p_rise_flag;
    s_rise_seen |=> st_r.rise_flag
        ##1 (st_r.rise_flag || $past(sfr_wr && sfr_addr == cmr_pkg::FLAG_ADDR));
  endproperty
  a_rise_flag: assert property (p_rise_flag) else $error("rise flag lost");

  property p_flag_hold;
    st_r.fall_flag && !(sfr_wr && sfr_addr == cmr_pkg::FLAG_ADDR) |=> st_r.fall_flag;
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("fall flag dropped");

  property p_sync_chain;
    ##2 st_r.sync2 == $past(raw_compare_in, 2);
  endproperty
  a_sync_chain: assert property (p_sync_chain) else $error("sync output wrong");

  // Interrupt enables, open side of the rise gate and closed side of the fall gate
  property p_rise_irq;
    st_r.rise_flag && st_r.mode[cmr_pkg::RISE_EN_BIT] |=> cmp_irq;
  endproperty
  a_rise_irq: assert property (p_rise_irq) else $error("rise irq missing");

  property p_fall_gate;
    st_r.fall_flag && !st_r.mode[cmr_pkg::FALL_EN_BIT] && !st_r.rise_flag |=> !cmp_irq;
  endproperty
  a_fall_gate: assert property (p_fall_gate) else $error("fall irq not blocked");

  // No flag, no interrupt, whatever the enables say
  property p_irq_idle;
    !st_r.rise_flag && !st_r.fall_flag |=> !cmp_irq;
  endproperty
  a_irq_idle: assert property (p_irq_idle) else $error("irq without flag");

  // Falling edge sets its flag like the rising one, checked one cycle on only
  sequence s_fall_seen;
    !st_r.sync2 && st_r.sync_prev;
  endsequence
  property p_fall_flag;
    s_fall_seen |=> st_r.fall_flag;
  endproperty
  a_fall_flag: assert property (p_fall_flag) else $error("fall flag not set");

  property p_rise_hold;
    st_r.rise_flag && !(sfr_wr && sfr_addr == cmr_pkg::FLAG_ADDR) |=> st_r.rise_flag;
  endproperty
  a_rise_hold: assert property (p_rise_hold) else $error("rise flag dropped");

  // Read port: unimplemented mode bits always read as zero
  property p_rd_mode;
    sfr_rd && sfr_addr == cmr_pkg::MODE_ADDR |=> (sfr_rdata & ~cmr_pkg::MODE_WMASK) == 8'h00;
  endproperty
  a_rd_mode: assert property (p_rd_mode) else $error("mode read not masked");

  property p_mux_rd;
    sfr_rd && sfr_addr == cmr_pkg::MUX_ADDR
        |=> sfr_rdata == {$past(neg_input_sel), $past(pos_input_sel)};
  endproperty
  a_mux_rd: assert property (p_mux_rd) else $error("input select read wrong");

  // Pin routing, open side of the raw enable and closed side of the sync enable
  property p_raw_pass;
    st_r.raw_en |-> raw_compare_out == raw_compare_in;
  endproperty
  a_raw_pass: assert property (p_raw_pass) else $error("raw pin not passed");

  property p_sync_gate;
    !crossbar_route_reg0[cmr_pkg::XBAR_SYNC_BIT] |=> !synced_compare_out;
  endproperty
  a_sync_gate: assert property (p_sync_gate) else $error("synced pin not gated");

  // Flag register read shows both flags as they stood
  property p_flag_rd;
    sfr_rd && sfr_addr == cmr_pkg::FLAG_ADDR
        |=> sfr_rdata[cmr_pkg::RISE_FLAG_BIT] == $past(st_r.rise_flag)
        && sfr_rdata[cmr_pkg::FALL_FLAG_BIT] == $past(st_r.fall_flag);
  endproperty
  a_flag_rd: assert property (p_flag_rd) else $error("flag read wrong");

endmodule
`default_nettype wire

// [cmr_pkg.sv]
package cmr_pkg;
  // Register addresses on the special-function-register bus
  localparam logic [7:0] MODE_ADDR = 8'h9d;
  localparam logic [7:0] MUX_ADDR = 8'h9f;
  localparam logic [7:0] FLAG_ADDR = 8'h9b;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h02;
  localparam logic [7:0] MUX_RST = 8'hff;
  // Mode register fields
  localparam int RISE_EN_BIT = 5;
  localparam int FALL_EN_BIT = 4;
  localparam logic [7:0] MODE_WMASK = 8'h33;
  localparam int RMODE_LSB = 0;
  localparam int RMODE_W = 2;
  // Flag register fields
  localparam int OUT_BIT = 6;
  localparam int RISE_FLAG_BIT = 5;
  localparam int FALL_FLAG_BIT = 4;
  // Input mux fields
  localparam int NEG_LSB = 4;
  localparam int POS_LSB = 0;
  localparam int SEL_W = 4;
  // Crossbar enables in route register 0
  localparam int XBAR_RAW_BIT = 5;
  localparam int XBAR_SYNC_BIT = 4;

  // All block state, registered as one word
  typedef struct packed {
    logic [7:0] mode;
    logic [7:0] mux;
    logic rise_flag;
    logic fall_flag;
    logic sync1;
    logic sync2;
    logic sync_prev;
    logic raw_en;
    logic sync_pin;
    logic irq;
    logic [7:0] rdata;
  } cmr_state_t;
endpackage

// [tb_comparator_mode_and_routing.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_comparator_mode_and_routing;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00, wdata = 8'h00, xbar = 8'h00, rdata;
  logic wr = 1'b0, rd = 1'b0, raw = 1'b0;
  logic [1:0] rmode;
  logic [3:0] psel, nsel;
  logic raw_o, sync_o, irq;
  int error_cnt = 0, checks_done = 0;
  logic [31:0] seed = 32'h3b86;
  // Reference model of the registers and edge flags
  logic [7:0] m_mode = 8'h02, m_mux = 8'hff;
  logic m_rise = 1'b0, m_fall = 1'b0;
  always #2 mclk = ~mclk;
  cmr_ctrl u_dut (.mclk(mclk), .rst(rst), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(wr),
    .sfr_rd(rd), .sfr_rdata(rdata), .crossbar_route_reg0(xbar), .raw_compare_in(raw),
    .response_mode(rmode), .pos_input_sel(psel), .neg_input_sel(nsel),
    .raw_compare_out(raw_o), .synced_compare_out(sync_o), .cmp_irq(irq));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask
  // Write strobe is one cycle; a spare cycle keeps strobes apart
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    if (a == cmr_pkg::MODE_ADDR) m_mode = d & 8'h33;
    if (a == cmr_pkg::MUX_ADDR) m_mux = d;
    if (a == cmr_pkg::FLAG_ADDR) m_rise = m_rise & d[5];
    if (a == cmr_pkg::FLAG_ADDR) m_fall = m_fall & d[4];
    @(negedge mclk);
    wr = 1'b0;
    @(negedge mclk);
  endtask
  // Read data is registered, so it is looked at one edge after the strobe
  task automatic rd_reg(input logic [7:0] a);
    logic [7:0] e;
    e = 8'h00;
    if (a == cmr_pkg::MODE_ADDR) e = m_mode;
    if (a == cmr_pkg::MUX_ADDR) e = m_mux;
    if (a == cmr_pkg::FLAG_ADDR) e = {1'b0, raw, m_rise, m_fall, 4'h0};
    addr = a;
    rd = 1'b1;
    @(negedge mclk);
    rd = 1'b0;
    chk("rdata", {8'h00, e}, {8'h00, rdata});
    @(negedge mclk);
  endtask
  // Edge flags are model-set here; six cycles covers sync and irq latency
  task automatic set_raw(input logic v);
    if (v && !raw) m_rise = 1'b1;
    if (!v && raw) m_fall = 1'b1;
    raw = v;
    repeat (6) @(negedge mclk);
  endtask
  task automatic state_chk();
    chk("ctl", {6'h00, m_mode[1:0], m_mux}, {6'h00, rmode, nsel, psel});
    chk("irq", {15'h0, (m_rise & m_mode[5]) | (m_fall & m_mode[4])}, {15'h0, irq});
    chk("pins", {14'h0, raw & xbar[4], raw & xbar[5]}, {14'h0, sync_o, raw_o});
  endtask
  task automatic end_of_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(negedge mclk);
    rst = 1'b0;
    @(negedge mclk);
    state_chk();
    rd_reg(cmr_pkg::MODE_ADDR);
    rd_reg(cmr_pkg::MUX_ADDR);
    rd_reg(cmr_pkg::FLAG_ADDR);
    // Random traffic; the low mode bits walk all four response codes
    for (int i = 0; i < 16; i++) begin
      seed = lfsr(seed);
      wr_reg(cmr_pkg::MODE_ADDR, {seed[7:2], i[1:0]});
      wr_reg(cmr_pkg::MUX_ADDR, seed[15:8]);
      wr_reg(8'h9e, seed[23:16]);
      xbar = seed[23:16];
      set_raw(seed[24]);
      state_chk();
      rd_reg(cmr_pkg::MODE_ADDR);
      rd_reg(cmr_pkg::MUX_ADDR);
      rd_reg(cmr_pkg::FLAG_ADDR);
      rd_reg(8'h9e);
      wr_reg(cmr_pkg::FLAG_ADDR, seed[31:24]);
      state_chk();
    end
    end_of_test();
  end
endmodule
`default_nettype wire
